// ---- rtl/sld_pkg.sv ----
// Purpose: Shared constants for the stall load detector.
// Assumes: Byte addressed Avalon-MM register window of five 32-bit words.
// Notes: Offsets are byte addresses; each register takes one aligned word.
`default_nettype none
package sld_pkg;
    localparam int ADDR_W = 5;
    localparam int POS_W = 10;
    localparam int SAMPLE_W = 8;
    localparam int LOAD_W = 10;
    localparam int THR_W = 8;
    localparam int VEL_W = 20;

    localparam logic [ADDR_W-1:0] OFS_STALL_THR = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_LOW_VEL_THR = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_LOAD_RESULT = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_STEP_INT = 5'h10;

    localparam logic [THR_W-1:0] RST_STALL_THR = 8'h00;
    localparam logic [VEL_W-1:0] RST_LOW_VEL_THR = 20'h0_0000;
    localparam logic [LOAD_W-1:0] RST_LOAD_RESULT = 10'h000;

    // Low byte of the microstep position at every half step point.
    localparam logic [7:0] HALF_STEP_LOW = 8'h80;
    // Microstep position at which the index pulse is issued.
    localparam logic [POS_W-1:0] INDEX_POS = 10'h080;

    localparam int ST_GATE_BIT = 0;
    localparam int ST_STALL_BIT = 1;
    localparam int ST_QUIET_BIT = 2;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- rtl/sld_stall_load_detector.sv ----
// Purpose: Per full step load result refresh, stall compare and diagnostic pulse.
// Assumes: Position, sample, mode and step interval inputs come from mclk logic.
// Notes: Registers sit behind an Avalon-MM slave with one wait state.
// Function
// - A stall is seen when the load result is below twice the stall threshold.
// - The load result spans 0 to 510, higher meaning lighter load.
// - A larger stall threshold flags a stall at lower torque.
// - The load result refreshes once per full step, at each half step position.
// - One refresh falls on the position where the index pulse is issued.
// - A stall gives a pulse on the diagnostic output, not a level.
// - The pulse is enabled only in quiet chopper mode with threshold at or above interval.
// - The load measurement has eight bits of effective resolution.
`default_nettype none
module sld_stall_load_detector (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [sld_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [sld_pkg::POS_W-1:0] microstep_pos,
    input wire logic [sld_pkg::SAMPLE_W-1:0] load_sample,
    input wire logic quiet_voltage_chopper_mode,
    input wire logic [sld_pkg::VEL_W-1:0] step_interval,
    output logic index_pulse,
    output logic load_refresh,
    output logic diagnostic_output
);
    import sld_pkg::*;

    logic [POS_W-1:0] pos_ff;
    logic [POS_W-1:0] nxt_pos;
    logic [LOAD_W-1:0] load_result_ff;
    logic [LOAD_W-1:0] nxt_load_result;
    logic diagnostic_output_ff;
    logic nxt_diagnostic_output;
    logic index_ff;
    logic nxt_index;
    logic refresh_ff;
    logic nxt_refresh;
    logic stall_seen_ff;
    logic nxt_stall_seen;

    logic [THR_W-1:0] stall_threshold_ff;
    logic [THR_W-1:0] nxt_stall_threshold;
    logic [VEL_W-1:0] low_velocity_threshold_ff;
    logic [VEL_W-1:0] nxt_low_velocity_threshold;
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    logic pos_moved;
    logic at_half_step;
    logic refresh_now;
    logic [LOAD_W-1:0] new_load;
    logic [LOAD_W-1:0] doubled_thr;
    logic stall_gate;
    logic is_stall;
    logic req;
    logic [31:0] wmerge_thr;
    logic [31:0] wmerge_vel;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Measurement path.
    always_comb begin
        nxt_pos = microstep_pos;
        pos_moved = (microstep_pos != pos_ff);
        at_half_step = (microstep_pos[7:0] == HALF_STEP_LOW);
        // The low eight position bits hit the half step value once per 256 microsteps.
        refresh_now = pos_moved && at_half_step;
        // A sample only ever holds 8 bits; the doubled value keeps the 0 to 510 span.
        new_load = {1'b0, load_sample, 1'b0};
        doubled_thr = {1'b0, stall_threshold_ff, 1'b0};
        stall_gate = quiet_voltage_chopper_mode
            && (low_velocity_threshold_ff >= step_interval);
        is_stall = (new_load < doubled_thr);
        nxt_load_result = load_result_ff;
        nxt_stall_seen = stall_seen_ff;
        nxt_diagnostic_output = 1'b0;
        nxt_refresh = refresh_now;
        // The index point is itself a half step point, so it refreshes as well.
        nxt_index = pos_moved && (microstep_pos == INDEX_POS);
        if (refresh_now) begin
            nxt_load_result = new_load;
            nxt_stall_seen = is_stall;
            // One cycle pulse per refresh, even while the stall persists.
            nxt_diagnostic_output = is_stall && stall_gate;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            // Track the position through reset so that release never looks like an arrival.
            pos_ff <= nxt_pos;
            load_result_ff <= RST_LOAD_RESULT;
            diagnostic_output_ff <= 1'b0;
            index_ff <= 1'b0;
            refresh_ff <= 1'b0;
            stall_seen_ff <= 1'b0;
        end else begin
            pos_ff <= nxt_pos;
            load_result_ff <= nxt_load_result;
            diagnostic_output_ff <= nxt_diagnostic_output;
            index_ff <= nxt_index;
            refresh_ff <= nxt_refresh;
            stall_seen_ff <= nxt_stall_seen;
        end
    end

    // Register slave. A request is answered one cycle after it appears, which keeps
    // read data registered at the cost of one wait state per access.
    always_comb begin
        req = avs_read || avs_write;
        nxt_ack = req && !ack_ff;
        nxt_rdata = rdata_ff;
        nxt_stall_threshold = stall_threshold_ff;
        nxt_low_velocity_threshold = low_velocity_threshold_ff;
        wmerge_thr = merge_bytes({24'h00_0000, stall_threshold_ff}, avs_writedata,
            avs_byteenable);
        wmerge_vel = merge_bytes({12'h000, low_velocity_threshold_ff}, avs_writedata,
            avs_byteenable);
        if (nxt_ack && avs_read) begin
            case (avs_address[ADDR_W-1:2])
                OFS_STALL_THR[ADDR_W-1:2]: begin
                    nxt_rdata = {24'h00_0000, stall_threshold_ff};
                end
                OFS_LOW_VEL_THR[ADDR_W-1:2]: begin
                    nxt_rdata = {12'h000, low_velocity_threshold_ff};
                end
                OFS_LOAD_RESULT[ADDR_W-1:2]: begin
                    nxt_rdata = {22'h00_0000, load_result_ff};
                end
                OFS_STATUS[ADDR_W-1:2]: begin
                    nxt_rdata = READ_ZERO;
                    nxt_rdata[ST_GATE_BIT] = stall_gate;
                    nxt_rdata[ST_STALL_BIT] = stall_seen_ff;
                    nxt_rdata[ST_QUIET_BIT] = quiet_voltage_chopper_mode;
                end
                OFS_STEP_INT[ADDR_W-1:2]: begin
                    nxt_rdata = {12'h000, step_interval};
                end
                default: begin
                    nxt_rdata = READ_ZERO;
                end
            endcase
        end
        if (ack_ff && avs_write) begin
            case (avs_address[ADDR_W-1:2])
                OFS_STALL_THR[ADDR_W-1:2]: begin
                    nxt_stall_threshold = wmerge_thr[THR_W-1:0];
                end
                OFS_LOW_VEL_THR[ADDR_W-1:2]: begin
                    nxt_low_velocity_threshold = wmerge_vel[VEL_W-1:0];
                end
                default: begin
                    nxt_stall_threshold = stall_threshold_ff;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
            rdata_ff <= READ_ZERO;
            stall_threshold_ff <= RST_STALL_THR;
            low_velocity_threshold_ff <= RST_LOW_VEL_THR;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
            stall_threshold_ff <= nxt_stall_threshold;
            low_velocity_threshold_ff <= nxt_low_velocity_threshold;
        end
    end

    assign avs_waitrequest = !ack_ff;
    assign avs_readdata = rdata_ff;
    assign diagnostic_output = diagnostic_output_ff;
    // One-cycle strobes at the ports only; the status register does not show them.
    assign index_pulse = index_ff;
    assign load_refresh = refresh_ff;
endmodule
`default_nettype wire

// ---- verification/sld_ctrl_model.sv ----
// Purpose: Controller that watches the diagnostic pulse.
// Assumes: Same clock as the detector.
// Notes: A single pulse latches the stop, as a level would hide a new stall.
`default_nettype none
module sld_ctrl_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic diagnostic_output,
    input wire logic load_refresh,
    output logic stop_motor,
    output int pulse_count,
    output int refresh_count
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            stop_motor <= 1'b0;
            pulse_count <= 0;
            refresh_count <= 0;
        end else begin
            stop_motor <= stop_motor | diagnostic_output;
            pulse_count <= pulse_count + int'(diagnostic_output);
            refresh_count <= refresh_count + int'(load_refresh);
        end
    end
endmodule
`default_nettype wire

// ---- verification/sld_monitor.sv ----
// Purpose: Port checks of the stall load detector.
// Assumes: One clock, synchronous reset.
// Notes: Thresholds are internal, so compare values are left to the bench.
`default_nettype none
module sld_monitor (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [sld_pkg::POS_W-1:0] microstep_pos,
    input wire logic quiet_voltage_chopper_mode,
    input wire logic index_pulse,
    input wire logic load_refresh,
    input wire logic diagnostic_output
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_REFRESH: assert property (microstep_pos != $past(microstep_pos) &&
        microstep_pos[7:0] == 8'h80 |=> load_refresh) else $error("no refresh");
    AST_ON_HALF: assert property (load_refresh |->
        $past(microstep_pos[7:0]) == 8'h80) else $error("stray refresh");
    AST_INDEX: assert property (index_pulse |-> load_refresh &&
        $past(microstep_pos) == 10'h080) else $error("bad index");
    AST_DIAGNOSTIC_OUTPUT_REF: assert property (diagnostic_output |-> load_refresh)
        else $error("diagnostic_output off refresh");
    AST_HOLD: assert property ($stable(microstep_pos) |=> !load_refresh)
        else $error("refresh on hold");
    AST_GATE: assert property (diagnostic_output |->
        $past(quiet_voltage_chopper_mode)) else $error("diagnostic_output not gated");
    AST_ACK: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("late ack");
    AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long ack");
endmodule
`default_nettype wire

// ---- verification/stall_load_detector_tb.sv ----
// Purpose: Self-checking bench of the stall load detector.
// Assumes: One bus request at a time, all byte lanes on.
// Notes: Expected figures come from the rules only.
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module stall_load_detector_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sld_pkg::*;
    typedef struct packed {
        logic [POS_W-1:0] p;
        logic [SAMPLE_W-1:0] s;
        logic [THR_W-1:0] t;
        logic q;
        logic [VEL_W-1:0] v;
        logic d;
    } sld_row_s;
    sld_row_s rows [7] = '{'{10'h080, 8'h0A, 8'h14, 1'b1, 20'h0_0064, 1'b1},
        '{10'h180, 8'h28, 8'h28, 1'b1, 20'h0_0064, 1'b0},
        '{10'h280, 8'h27, 8'h28, 1'b1, 20'h0_0032, 1'b1},
        '{10'h380, 8'h0A, 8'h14, 1'b0, 20'h0_0064, 1'b0},
        '{10'h080, 8'h0A, 8'h14, 1'b1, 20'h0_0031, 1'b0},
        '{10'h180, 8'hFF, 8'hFF, 1'b1, 20'h0_0064, 1'b0},
        '{10'h280, 8'h00, 8'h01, 1'b1, 20'h0_0064, 1'b1}};
    logic mclk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic quiet_voltage_chopper_mode = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, index_pulse, load_refresh, diagnostic_output, stop_motor;
    logic [POS_W-1:0] microstep_pos = '0;
    logic [SAMPLE_W-1:0] load_sample = '0;
    logic [VEL_W-1:0] step_interval = 20'h0_0032;
    int err_count = 0, cmp_count = 0, pulse_count, refresh_count, exp_p = 0;
    always #25 mclk = ~mclk;
    sld_stall_load_detector i_dut (.mclk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .microstep_pos,
        .load_sample, .quiet_voltage_chopper_mode, .step_interval, .index_pulse,
        .load_refresh, .diagnostic_output);
    sld_ctrl_model i_ctrl (.mclk, .resetn, .diagnostic_output, .load_refresh, .stop_motor,
        .pulse_count, .refresh_count);
    task automatic print_verdict;
        if (err_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            print_verdict();
        end
        @(posedge mclk);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, ADDR_W'(i * 4), '0);
            `CHK(rd, READ_ZERO)
        end
        foreach (rows[i]) begin
            bus(1'b1, OFS_STALL_THR, {24'h00_0000, rows[i].t});
            bus(1'b1, OFS_LOW_VEL_THR, {12'h000, rows[i].v});
            quiet_voltage_chopper_mode <= rows[i].q;
            load_sample <= rows[i].s;
            microstep_pos <= rows[i].p - 10'h001;
            @(posedge mclk);
            microstep_pos <= rows[i].p;
            repeat (2) @(posedge mclk);
            `CHK(diagnostic_output, rows[i].d)
            `CHK(index_pulse, rows[i].p == INDEX_POS)
            `CHK(load_refresh, 1'b1)
            @(posedge mclk);
            `CHK({load_refresh, diagnostic_output}, 2'b00)
            exp_p += int'(rows[i].d);
            bus(1'b0, OFS_LOAD_RESULT, '0);
            `CHK(rd, {23'h00_0000, rows[i].s, 1'b0})
        end
        repeat (3) @(posedge mclk);
        `CHK(refresh_count, 7)
        `CHK(pulse_count, exp_p)
        `CHK(stop_motor, 1'b1)
        bus(1'b1, OFS_LOAD_RESULT, 32'h0000_FFFF);
        bus(1'b0, OFS_LOAD_RESULT, '0);
        `CHK(rd, READ_ZERO)
        bus(1'b0, 5'h14, '0);
        `CHK(rd, READ_ZERO)
        bus(1'b1, OFS_LOW_VEL_THR, 32'hFFFF_FFFF);
        bus(1'b0, OFS_LOW_VEL_THR, '0);
        `CHK(rd, 32'h000F_FFFF)
        bus(1'b0, OFS_STATUS, '0);
        `CHK(rd, 32'h0000_0007)
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        `CHK({avs_waitrequest, load_refresh, diagnostic_output}, 3'b100)
        @(posedge mclk);
        `CHK(load_refresh, 1'b0)
        bus(1'b0, OFS_STALL_THR, '0);
        `CHK(rd, READ_ZERO)
        print_verdict();
    end
endmodule
bind sld_stall_load_detector sld_monitor i_mon (.mclk, .resetn, .avs_read, .avs_write,
    .avs_waitrequest, .microstep_pos, .quiet_voltage_chopper_mode, .index_pulse,
    .load_refresh, .diagnostic_output);
`default_nettype wire
